// ==== hw/psf_pkg.sv ====
/*
 * Constants, field layout and state codes of the protection switch
 * fault controller. Assumes a 50 MHz aclk and comparator inputs that
 * are already synchronous to it.
 */
// How it works
// R01: enabled only while enable is high and supply lockout inactive.
// R02: switch may turn on only with supply above lockout threshold.
// R03: threshold select latched at enable, later changes ignored.
// R04: select low picks higher trip, select high picks lower trip.
// R05: over-voltage with switch on turns it off after debounce.
// R06: over-voltage debounce is 512 us.
// R07: over-voltage keeps an off switch from turning on.
// R08: over-voltage protection pulls the fault flag low.
// R09: reverse current comparator forces the switch off.
// R10: thermal shutdown turns the switch off.
// R11: auto-restart waits for thermal release point before turn-on.
// R12: latch-off variant stays off until enable toggles or power cycles.
// R13: at enable check faults, then turn on after enable delay.
// R14: startup timer trips after 500 us continuous current limit.
// R15: limit timer disabled once switch fully on.
// R16: auto-restart retries short every 64 ms until disabled.
// R17: latch-off retries short 4 times every 2 ms then latches.
// R18: at enable faults withhold turn-on; flag only for ov and thermal.
// R19: reverse current clear turns on without soft-start, flag released.
// R20: faults watched while enabled, short only during soft-start.
// R21: auto-restart resumes with soft-start after ov or thermal clears.
// R22: far side drives enable to a definite level.
// R23: recovery policy is a build-time parameter.
// R24: comparator results are synchronous inputs, times counted in clocks.
package psf_pkg;
   // clock and timing
   localparam int unsigned CLK_MHZ          = 50;
   localparam int unsigned OV_DEBOUNCE_US   = 512;
   localparam int unsigned OV_DEBOUNCE_CYC  = OV_DEBOUNCE_US * CLK_MHZ;
   localparam int unsigned SHORT_LIMIT_US   = 500;
   localparam int unsigned SHORT_LIMIT_CYC  = SHORT_LIMIT_US * CLK_MHZ;
   localparam int unsigned RETRY_PERIOD_MS  = 64;
   localparam int unsigned RETRY_PERIOD_CYC =
      RETRY_PERIOD_MS * 1000 * CLK_MHZ;
   localparam int unsigned RETRY_INTVL_MS   = 2;
   localparam int unsigned RETRY_INTVL_CYC  = RETRY_INTVL_MS * 1000 * CLK_MHZ;
   localparam int unsigned EN_DELAY_MS      = 9;
   localparam int unsigned EN_DELAY_CYC     = EN_DELAY_MS * 1000 * CLK_MHZ;
   localparam int unsigned RETRY_COUNT      = 4;

   // register map
   localparam logic [7:0] CTRL_OFS          = 8'h00;
   localparam logic [7:0] STATUS_OFS        = 8'h04;
   localparam int unsigned CTRL_FORCE_BIT   = 0;
   localparam logic        CTRL_RESET       = 1'b0;
   localparam int unsigned ST_STATE_LSB     = 0;
   localparam int unsigned ST_GATE_BIT      = 3;
   localparam int unsigned ST_SOFT_BIT      = 4;
   localparam int unsigned ST_FLT_BIT       = 5;
   localparam int unsigned ST_OVSEL_BIT     = 6;
   localparam int unsigned ST_HOT_BIT       = 7;
   localparam int unsigned ST_RETRY_LSB     = 8;
   localparam int unsigned ST_EN_BIT        = 11;
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // gray codes along idle, check, delay, soft-start, on
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h0,
      ST_CHECK   = 3'h1,
      ST_DELAY   = 3'h3,
      ST_SOFT    = 3'h2,
      ST_ON      = 3'h6,
      ST_RETRY   = 3'h7,
      ST_HOLD    = 3'h5,
      ST_LATCHED = 3'h4
   } psf_state_t;
endpackage

// ==== hw/psf_fault_ctrl.sv ====
/*
 * Fault control state machine of a high-side protection switch, with an
 * AXI4-Lite register slave for a force-off control and a status word.
 * Assumes comparator inputs synchronous to aclk and a single 50 MHz clock.
 */
module psf_fault_ctrl
   import psf_pkg::*;
#(
   // R23 build-time policy
   parameter bit          AUTO_RESTART = 1'b1,
   parameter int unsigned OVD_CYC      = OV_DEBOUNCE_CYC,
   parameter int unsigned SHORT_CYC    = SHORT_LIMIT_CYC,
   parameter int unsigned RPER_CYC     = RETRY_PERIOD_CYC,
   parameter int unsigned RINT_CYC     = RETRY_INTVL_CYC,
   parameter int unsigned EDLY_CYC     = EN_DELAY_CYC
)(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        enable,
   input  wire logic        input_undervoltage_lockout,
   input  wire logic        overvoltage_level_select,
   input  wire logic        ov_above_high_level,
   input  wire logic        ov_above_low_level,
   input  wire logic        thermal_shutdown,
   input  wire logic        thermal_cooled,
   input  wire logic        reverse_current_block,
   input  wire logic        current_limit_active,
   input  wire logic        soft_start_done,
   output logic             switch_gate_on,
   output logic             soft_start_run,
   output logic             fault_flag_n_o,
   output logic             fault_flag_n_oe,
   input  wire logic [7:0]  s_axil_awaddr,
   input  wire logic        s_axil_awvalid,
   output logic             s_axil_awready,
   input  wire logic [31:0] s_axil_wdata,
   input  wire logic [3:0]  s_axil_wstrb,
   input  wire logic        s_axil_wvalid,
   output logic             s_axil_wready,
   output logic [1:0]       s_axil_bresp,
   output logic             s_axil_bvalid,
   input  wire logic        s_axil_bready,
   input  wire logic [7:0]  s_axil_araddr,
   input  wire logic        s_axil_arvalid,
   output logic             s_axil_arready,
   output logic [31:0]      s_axil_rdata,
   output logic [1:0]       s_axil_rresp,
   output logic             s_axil_rvalid,
   input  wire logic        s_axil_rready
);

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      psf_state_t  state;
      logic        ov_sel_low;
      logic        hot_flag;
      logic        resume_on;
      logic [2:0]  retries;
      logic [31:0] cnt;
      logic [31:0] ov_cnt;
      logic        gate;
      logic        ss_run;
      logic        flt_o;
      logic        flt_oe;
      logic        force_off;
      logic        aw_held;
      logic        w_held;
      logic [7:0]  awaddr;
      logic [31:0] wdata;
      logic        wstrb0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } psf_regs_t;

   localparam int unsigned RWAIT_CYC = AUTO_RESTART ? RPER_CYC : RINT_CYC;

   psf_regs_t s_reg;
   psf_regs_t s_next;
   logic      enabled;
   logic      ov_now;
   logic      ov_trip;
   logic      fault_any;

   // R01 R02: lockout and the software force-off both disable
   assign enabled   = enable & ~input_undervoltage_lockout & ~s_reg.force_off;
   // R04: captured select picks the comparator
   assign ov_now    = s_reg.ov_sel_low ? ov_above_low_level
                                       : ov_above_high_level;
   // R05 R06: trip on the last debounce cycle
   assign ov_trip   = ov_now && (s_reg.ov_cnt == OVD_CYC - 1);
   assign fault_any = ov_now | s_reg.hot_flag | reverse_current_block;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      // R10 R11: hot set wins, release only below the lower point
      s_next.hot_flag = thermal_shutdown | (s_reg.hot_flag & ~thermal_cooled);
      // R24 times counted in clocks
      s_next.ov_cnt   = (ov_now && s_reg.gate) ? s_reg.ov_cnt + 32'h1 : '0;
      s_next.flt_o    = 1'b0;

      if (!enabled) begin
         // R12: losing enabled (enable low, lockout or force-off) is the only way out of a latch
         s_next.state     = ST_IDLE;
         s_next.gate      = 1'b0;
         s_next.ss_run    = 1'b0;
         s_next.retries   = '0;
         s_next.cnt       = '0;
         s_next.resume_on = 1'b0;
      end else begin
         unique case (s_reg.state)
            ST_IDLE: begin
               // R03: latch the level selection once per enable
               s_next.ov_sel_low = overvoltage_level_select;
               s_next.state      = ST_CHECK;
            end
            ST_CHECK: begin
               // R13 R18: withhold turn-on while any fault exists
               s_next.cnt = '0;
               if (fault_any) begin
                  s_next.state     = ST_HOLD;
                  s_next.resume_on = 1'b0;
               end else begin
                  s_next.state = ST_DELAY;
               end
            end
            ST_DELAY: begin
               // R07 R13: count the enable delay before soft-start
               if (fault_any) begin
                  s_next.state = ST_HOLD;
               end else if (s_reg.cnt == EDLY_CYC - 1) begin
                  s_next.state  = ST_SOFT;
                  s_next.gate   = 1'b1;
                  s_next.ss_run = 1'b1;
                  s_next.cnt    = '0;
               end else begin
                  s_next.cnt = s_reg.cnt + 32'h1;
               end
            end
            ST_SOFT: begin
               // R09 R10 R05: thermal, reverse and debounced ov stop it
               if (s_reg.hot_flag || reverse_current_block || ov_trip) begin
                  s_next.state     = ST_HOLD;
                  s_next.gate      = 1'b0;
                  s_next.ss_run    = 1'b0;
                  s_next.resume_on = 1'b0;
               end else if (soft_start_done) begin
                  // R15: limit timer no longer runs once fully on
                  s_next.state  = ST_ON;
                  s_next.ss_run = 1'b0;
                  s_next.cnt    = '0;
               end else if (current_limit_active) begin
                  // R14 R20: continuous limiting for the timer period
                  if (s_reg.cnt == SHORT_CYC - 1) begin
                     s_next.gate   = 1'b0;
                     s_next.ss_run = 1'b0;
                     s_next.cnt    = '0;
                     // R16 R17: retry policy of the variant
                     if (!AUTO_RESTART &&
                         s_reg.retries == 3'(RETRY_COUNT)) begin
                        s_next.state = ST_LATCHED;
                     end else begin
                        s_next.state = ST_RETRY;
                        if (!AUTO_RESTART) begin
                           s_next.retries = s_reg.retries + 3'h1;
                        end
                     end
                  end else begin
                     s_next.cnt = s_reg.cnt + 32'h1;
                  end
               end else begin
                  // R14: timer restarts when current drops below limit
                  s_next.cnt = '0;
               end
            end
            ST_ON: begin
               // R09 R10 R05 R20
               if (s_reg.hot_flag || reverse_current_block || ov_trip) begin
                  s_next.state     = ST_HOLD;
                  s_next.gate      = 1'b0;
                  s_next.resume_on = reverse_current_block &
                                     ~s_reg.hot_flag & ~ov_trip;
               end
            end
            ST_RETRY: begin
               // R16 R17: wait the retry period, then soft-start again
               if (ov_now || s_reg.hot_flag) begin
                  s_next.state = ST_HOLD;
                  s_next.cnt   = '0;
               end else if (s_reg.cnt == RWAIT_CYC - 1) begin
                  s_next.state  = ST_SOFT;
                  s_next.gate   = 1'b1;
                  s_next.ss_run = 1'b1;
                  s_next.cnt    = '0;
               end else begin
                  s_next.cnt = s_reg.cnt + 32'h1;
               end
            end
            ST_HOLD: begin
               s_next.cnt = '0;
               if (!AUTO_RESTART && (ov_now || s_reg.hot_flag)) begin
                  // R12: latch-off for over-voltage and thermal faults
                  s_next.state = ST_LATCHED;
               end else if (!fault_any) begin
                  s_next.gate = 1'b1;
                  if (s_reg.resume_on) begin
                     // R19: reverse current cleared, no soft-start
                     s_next.state = ST_ON;
                  end else begin
                     // R21 R11: soft-start after ov or thermal clears
                     s_next.state  = ST_SOFT;
                     s_next.ss_run = 1'b1;
                  end
                  s_next.resume_on = 1'b0;
               end
            end
            ST_LATCHED: begin
               s_next.gate   = 1'b0;
               s_next.ss_run = 1'b0;
            end
         endcase
      end

      // R08 R18: flag for ov, thermal and startup short, never reverse
      s_next.flt_oe = enabled & (ov_now | s_next.hot_flag |
                      s_next.state == ST_RETRY |
                      (s_next.state == ST_LATCHED &
                       s_next.retries == 3'(RETRY_COUNT)) |
                      (s_next.state == ST_LATCHED & ~AUTO_RESTART &
                       s_reg.state == ST_HOLD));
      if (s_reg.state == ST_LATCHED && enabled) begin
         s_next.flt_oe = 1'b1;
      end

      ////////////////////////////////////////////////////////////////////
      // write channel: address and data taken in either order
      if (s_axil_awvalid && s_reg.awready) begin
         s_next.aw_held = 1'b1;
         s_next.awaddr  = s_axil_awaddr;
      end
      if (s_axil_wvalid && s_reg.wready) begin
         s_next.w_held = 1'b1;
         s_next.wdata  = s_axil_wdata;
         s_next.wstrb0 = s_axil_wstrb[0];
      end
      if (s_reg.bvalid && s_axil_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_held && s_reg.w_held && !s_reg.bvalid) begin
         s_next.aw_held = 1'b0;
         s_next.w_held  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = RESP_OKAY;
         if (s_reg.awaddr == CTRL_OFS) begin
            if (s_reg.wstrb0) begin
               s_next.force_off = s_reg.wdata[CTRL_FORCE_BIT];
            end
         end else if (s_reg.awaddr != STATUS_OFS) begin
            s_next.bresp = RESP_SLVERR;
         end
      end
      s_next.awready = ~s_next.aw_held & ~s_next.bvalid;
      s_next.wready  = ~s_next.w_held & ~s_next.bvalid;

      // read channel: one outstanding read
      if (s_reg.rvalid && s_axil_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axil_arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = RESP_OKAY;
         s_next.rdata  = '0;
         if (s_axil_araddr == CTRL_OFS) begin
            s_next.rdata[CTRL_FORCE_BIT] = s_reg.force_off;
         end else if (s_axil_araddr == STATUS_OFS) begin
            s_next.rdata[ST_STATE_LSB +: 3] = s_reg.state;
            s_next.rdata[ST_GATE_BIT]       = s_reg.gate;
            s_next.rdata[ST_SOFT_BIT]       = s_reg.ss_run;
            s_next.rdata[ST_FLT_BIT]        = s_reg.flt_oe;
            s_next.rdata[ST_OVSEL_BIT]      = s_reg.ov_sel_low;
            s_next.rdata[ST_HOT_BIT]        = s_reg.hot_flag;
            s_next.rdata[ST_RETRY_LSB +: 3] = s_reg.retries;
            s_next.rdata[ST_EN_BIT]         = enabled;
         end else begin
            s_next.rresp = RESP_SLVERR;
         end
      end
      s_next.arready = ~s_next.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg           <= '0;
         s_reg.force_off <= CTRL_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   assign switch_gate_on  = s_reg.gate;
   assign soft_start_run  = s_reg.ss_run;
   assign fault_flag_n_o  = s_reg.flt_o;
   assign fault_flag_n_oe = s_reg.flt_oe;
   assign s_axil_awready  = s_reg.awready;
   assign s_axil_wready   = s_reg.wready;
   assign s_axil_bvalid   = s_reg.bvalid;
   assign s_axil_bresp    = s_reg.bresp;
   assign s_axil_arready  = s_reg.arready;
   assign s_axil_rvalid   = s_reg.rvalid;
   assign s_axil_rdata    = s_reg.rdata;
   assign s_axil_rresp    = s_reg.rresp;

   ////////////////////////////////////////////////////////////////////////
   // helper counters seen only by the checks below
   logic [31:0] ovrun_reg;
   logic [31:0] shortrun_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ovrun_reg    <= '0;
         shortrun_reg <= '0;
      end else begin
         ovrun_reg    <= (s_reg.gate && ov_now) ? ovrun_reg + 32'h1 : '0;
         shortrun_reg <= (s_reg.state == ST_SOFT && current_limit_active)
                         ? shortrun_reg + 32'h1 : '0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence enabled_ov_s;
      enabled && ov_now;
   endsequence
   sequence gate_kept_off_s;
      !switch_gate_on;
   endsequence

   a_gate_needs_enable: assert property ( // R01
      !enabled |=> !switch_gate_on)
      else $error("switch on while not enabled");
   a_ov_select_held: assert property ( // R03
      $past(s_reg.state) != ST_IDLE && s_reg.state != ST_IDLE
      |-> $stable(s_reg.ov_sel_low))
      else $error("threshold selection changed after capture");
   a_ov_debounce_max: assert property ( // R05
      ovrun_reg <= OVD_CYC)
      else $error("switch stayed on past over-voltage debounce");
   a_ov_blocks_on: assert property ( // R07
      enabled_ov_s ##0 !switch_gate_on |=> gate_kept_off_s)
      else $error("switch turned on during over-voltage");
   a_ov_flag_low: assert property ( // R08
      enabled_ov_s |=> fault_flag_n_oe && !fault_flag_n_o)
      else $error("fault flag not pulled for over-voltage");
   a_reverse_off: assert property ( // R09
      enabled && reverse_current_block && switch_gate_on |=> !switch_gate_on)
      else $error("reverse current did not turn switch off");
   a_thermal_off: assert property ( // R10
      thermal_shutdown |=> ##1 !switch_gate_on)
      else $error("thermal shutdown did not turn switch off");
   a_short_timer_max: assert property ( // R14
      shortrun_reg <= SHORT_CYC)
      else $error("current limit exceeded startup timer");
   a_on_no_softstart: assert property ( // R15
      s_reg.state == ST_ON |-> !soft_start_run)
      else $error("soft-start running with switch fully on");
   a_latch_holds: assert property ( // R12
      !AUTO_RESTART && s_reg.state == ST_LATCHED && enabled
      |=> s_reg.state == ST_LATCHED && !switch_gate_on)
      else $error("latched-off switch left latch while enabled");

endmodule

// ==== dv/psf_host_model.sv ====
/*
 * Host controller model: drives the enable pin and reads the fault flag.
 * Assumes the bench hands it an enable request and that the open-drain
 * flag line has a pull-up on the board.
 */
module psf_host_model
   import psf_pkg::*;
(
   input  wire logic aclk,
   input  wire logic en_req,
   input  wire logic flag_o,
   input  wire logic flag_oe,
   output logic      enable,
   output logic      flag_level_n
);
   timeunit 1ns;
   timeprecision 1ps;

   always @(posedge aclk) enable <= (en_req === 1'b1);

   // released flag rests at the pull-up level
   assign flag_level_n = flag_oe ? flag_o : 1'b1;
endmodule

// ==== dv/psf_fault_ctrl_tb.sv ====
/*
 * Self-checking bench for the protection switch fault controller,
 * both builds, short counts. Assumes the host model drives enable
 * and the bench plays the comparators and the AXI4-Lite master.
 */
module psf_fault_ctrl_tb;
   import psf_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int OVD   = 16;
   localparam int SHORT = 12;
   localparam int RPER  = 60;
   localparam int RINT  = 30;
   localparam int EDLY  = 24;
   typedef struct {int idx; logic [31:0] exp;} psf_note_t;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        en_req, enable, input_undervoltage_lockout;
   logic        overvoltage_level_select, ov_above_high_level;
   logic        ov_above_low_level, thermal_shutdown, thermal_cooled;
   logic        reverse_current_block, current_limit_active;
   logic        soft_start_done, switch_gate_on, soft_start_run;
   logic        fault_flag_n_o, fault_flag_n_oe, flag_n, latch_gate;
   logic [7:0]  s_axil_awaddr, s_axil_araddr;
   logic [31:0] s_axil_wdata, s_axil_rdata, rd;
   logic [3:0]  s_axil_wstrb;
   logic [1:0]  s_axil_bresp, s_axil_rresp, resp;
   logic        s_axil_awvalid, s_axil_awready, s_axil_wvalid;
   logic        s_axil_wready, s_axil_bvalid, s_axil_bready;
   logic        s_axil_arvalid, s_axil_arready, s_axil_rvalid;
   logic        s_axil_rready;
   logic [31:0] seed = 32'hC31FE54B;
   int          err_total = 0;
   int          samples_checked = 0;
   psf_note_t   notes[$];
   psf_note_t   n;
   string       nm [7] = '{"gate", "soft", "flag", "rdata", "resp", "ovsel",
                           "lgate"};

   always #10 aclk = ~aclk;

   psf_fault_ctrl #(.AUTO_RESTART(1'b1), .OVD_CYC(OVD), .SHORT_CYC(SHORT),
      .RPER_CYC(RPER), .RINT_CYC(RINT), .EDLY_CYC(EDLY)) u_dut (
      .aclk, .aresetn, .enable, .input_undervoltage_lockout,
      .overvoltage_level_select, .ov_above_high_level, .ov_above_low_level,
      .thermal_shutdown, .thermal_cooled, .reverse_current_block,
      .current_limit_active, .soft_start_done, .switch_gate_on,
      .soft_start_run, .fault_flag_n_o, .fault_flag_n_oe, .s_axil_awaddr,
      .s_axil_awvalid, .s_axil_awready, .s_axil_wdata, .s_axil_wstrb,
      .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
      .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready,
      .s_axil_rdata, .s_axil_rresp, .s_axil_rvalid, .s_axil_rready);

   psf_fault_ctrl #(.AUTO_RESTART(1'b0), .OVD_CYC(OVD), .SHORT_CYC(SHORT),
      .RPER_CYC(RPER), .RINT_CYC(RINT), .EDLY_CYC(EDLY)) u_dut_latch (.*,
      .switch_gate_on(latch_gate), .soft_start_run(), .fault_flag_n_o(),
      .fault_flag_n_oe(), .s_axil_awready(), .s_axil_wready(),
      .s_axil_bresp(), .s_axil_bvalid(), .s_axil_arready(), .s_axil_rdata(),
      .s_axil_rresp(), .s_axil_rvalid());

   psf_host_model u_host (.aclk(aclk), .en_req(en_req), .enable(enable),
      .flag_o(fault_flag_n_o), .flag_oe(fault_flag_n_oe),
      .flag_level_n(flag_n));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [31:0] obs(input int i);
      case (i)
         0: return {31'h0, switch_gate_on};
         1: return {31'h0, soft_start_run};
         2: return {31'h0, flag_n};
         3: return rd;
         4: return {30'h0, resp};
         6: return {31'h0, latch_gate};
         default: return {31'h0, rd[ST_OVSEL_BIT]};
      endcase
   endfunction

   task automatic check(input string s, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", s, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge aclk);
   endtask

   task automatic note(input int i, input logic [31:0] v);
      notes.push_back('{i, v});
   endtask

   // outputs looked at 1 ns past the edge, once settled
   task automatic look(input int i, input logic [31:0] v);
      #1;
      note(i, v);
   endtask

   task automatic wait_for(input int i, input logic [31:0] v, input int mx);
      int k;
      k = 0;
      #1;
      while (obs(i) !== v && k < mx) begin
         @(posedge aclk);
         #1;
         k++;
      end
      note(i, v);
   endtask

   task automatic rnd_gap;
      seed = xs(seed);
      cyc(int'(seed[2:0]) + 1);
   endtask

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_go;
      logic w_go;
      @(posedge aclk);
      s_axil_awaddr  <= a;
      s_axil_awvalid <= 1'b1;
      s_axil_wdata   <= d;
      s_axil_wstrb   <= 4'hF;
      s_axil_wvalid  <= 1'b1;
      s_axil_bready  <= 1'b1;
      aw_go = 1'b1;
      w_go  = 1'b1;
      do begin
         @(posedge aclk);
         if (aw_go && s_axil_awready) begin
            s_axil_awvalid <= 1'b0;
            aw_go = 1'b0;
         end
         if (w_go && s_axil_wready) begin
            s_axil_wvalid <= 1'b0;
            w_go = 1'b0;
         end
      end while (s_axil_bvalid !== 1'b1);
      resp = s_axil_bresp;
      s_axil_bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      s_axil_araddr  <= a;
      s_axil_arvalid <= 1'b1;
      s_axil_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axil_arready) s_axil_arvalid <= 1'b0;
      end while (s_axil_rvalid !== 1'b1);
      rd   = s_axil_rdata;
      resp = s_axil_rresp;
      s_axil_rready <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial forever begin
      wait (notes.size() != 0);
      n = notes[0];
      check(nm[n.idx], obs(n.idx), n.exp);
      void'(notes.pop_front());
   end

   initial begin
      repeat (6000) @(posedge aclk);
      err_total++;
      report_and_stop();
   end

   initial begin
      {en_req, overvoltage_level_select, ov_above_high_level} = '0;
      {ov_above_low_level, thermal_shutdown, thermal_cooled} = '0;
      {reverse_current_block, current_limit_active, soft_start_done} = '0;
      {s_axil_awaddr, s_axil_awvalid, s_axil_wdata, s_axil_wstrb} = '0;
      {s_axil_wvalid, s_axil_bready, s_axil_araddr} = '0;
      {s_axil_arvalid, s_axil_rready, rd, resp} = '0;
      input_undervoltage_lockout = 1'b1;
      cyc(16);
      aresetn <= 1'b1;
      axi_rd(CTRL_OFS);
      note(3, 32'h0);
      axi_rd(STATUS_OFS);
      note(3, 32'h0);
      axi_rd(8'h08);
      note(4, {30'h0, RESP_SLVERR});
      axi_wr(CTRL_OFS, 32'h1);
      axi_rd(CTRL_OFS);
      note(3, 32'h1);
      axi_wr(CTRL_OFS, 32'h0);
      note(4, {30'h0, RESP_OKAY});
      $display("registers done");
      en_req <= 1'b1;
      cyc(EDLY + 8);
      look(0, 32'h0);
      cyc(1);
      input_undervoltage_lockout <= 1'b0;
      cyc(EDLY);
      look(0, 32'h0);
      wait_for(0, 32'h1, 12);
      look(1, 32'h1);
      axi_rd(STATUS_OFS);
      note(5, 32'h0);
      soft_start_done <= 1'b1;
      current_limit_active <= 1'b1;
      cyc(2);
      look(1, 32'h0);
      cyc(SHORT + 6);
      look(0, 32'h1);
      look(6, 32'h1);
      $display("startup done");
      cyc(1);
      current_limit_active <= 1'b0;
      reverse_current_block <= 1'b1;
      cyc(3);
      look(0, 32'h0);
      look(2, 32'h1);
      cyc(1);
      reverse_current_block <= 1'b0;
      cyc(4);
      look(0, 32'h1);
      look(1, 32'h0);
      $display("reverse done");
      cyc(1);
      thermal_shutdown <= 1'b1;
      soft_start_done <= 1'b0;
      cyc(4);
      look(0, 32'h0);
      look(2, 32'h0);
      cyc(1);
      thermal_shutdown <= 1'b0;
      cyc(6);
      look(0, 32'h0);
      cyc(1);
      thermal_cooled <= 1'b1;
      wait_for(1, 32'h1, 12);
      look(6, 32'h0);
      look(2, 32'h1);
      cyc(1);
      soft_start_done <= 1'b1;
      axi_wr(CTRL_OFS, 32'h1);
      cyc(2);
      look(0, 32'h0);
      axi_wr(CTRL_OFS, 32'h0);
      $display("thermal and force done");
      en_req <= 1'b0;
      soft_start_done <= 1'b0;
      current_limit_active <= 1'b1;
      rnd_gap();
      en_req <= 1'b1;
      wait_for(1, 32'h1, EDLY + 12);
      cyc(SHORT - 3);
      look(0, 32'h1);
      cyc(6);
      look(0, 32'h0);
      look(2, 32'h0);
      wait_for(1, 32'h1, RPER + 12);
      look(2, 32'h1);
      cyc(1);
      current_limit_active <= 1'b0;
      soft_start_done <= 1'b1;
      en_req <= 1'b0;
      overvoltage_level_select <= 1'b1;
      rnd_gap();
      en_req <= 1'b1;
      cyc(4);
      // later select changes must not move the trip level
      seed = xs(seed);
      overvoltage_level_select <= seed[4];
      wait_for(0, 32'h1, EDLY + 12);
      axi_rd(STATUS_OFS);
      note(5, 32'h1);
      ov_above_low_level <= 1'b1;
      cyc(OVD - 1);
      look(0, 32'h1);
      cyc(4);
      look(0, 32'h0);
      look(2, 32'h0);
      cyc(1);
      en_req <= 1'b0;
      overvoltage_level_select <= 1'b1;
      cyc(4);
      en_req <= 1'b1;
      cyc(EDLY + 10);
      look(0, 32'h0);
      look(2, 32'h0);
      cyc(1);
      ov_above_low_level <= 1'b0;
      wait_for(0, 32'h1, EDLY + 12);
      look(2, 32'h1);
      look(6, 32'h0);
      $display("overvoltage done");
      cyc(2);
      report_and_stop();
   end
endmodule
